/* common/isel_pkg.sv */
package isel_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [15:0] LINE0_EN_OFFSET   = 16'h3008;
    localparam logic [15:0] LINE1_EN_OFFSET   = 16'h300c;
    localparam logic [15:0] LINE0_FLAG_OFFSET = 16'h3010;
    localparam logic [15:0] LINE1_FLAG_OFFSET = 16'h3014;
    localparam logic [31:0] EN_RESET          = 32'h0000_2000;
    localparam logic [31:0] FLAG_RESET        = 32'h0000_0000;
    // implemented source bits; reserved 30, 28, 22..18, 14 read as zero
    localparam logic [31:0] SRC_MASK          = 32'hAF83_BFFF;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int BREAK_ATTEMPT_BIT   = 31;
    localparam int OUTLIER_BIT         = 29;
    localparam int FIFO_UNDERFLOW_BIT  = 27;
    localparam int FIFO_OVERFLOW_BIT   = 26;
    localparam int FIFO_THRESHOLD_BIT  = 25;
    localparam int FIFO_EMPTY_BIT      = 24;
    localparam int FIFO_FULL_BIT       = 23;
    localparam int SEQ_TMO_ERROR_BIT   = 17;
    localparam int SEQ_TMO_DONE_BIT    = 16;
    localparam int SEQ_END_BIT         = 15;
    localparam int BOOT_DONE_BIT       = 13;
    localparam int CUSTOM3_BIT         = 12;
    localparam int CUSTOM2_BIT         = 11;
    localparam int CUSTOM1_BIT         = 10;
    localparam int CUSTOM0_BIT         = 9;
    localparam int VARIANCE_BIT        = 8;
    localparam int MEAN_BIT            = 7;
    localparam int ADC_DELTA_BIT       = 6;
    localparam int ADC_MAX_BIT         = 5;
    localparam int ADC_MIN_BIT         = 4;
    localparam int TEMP_RESULT_BIT     = 3;
    localparam int FILTER_READY_BIT    = 2;
    localparam int DFT_RESULT_BIT      = 1;
    localparam int ADC_RESULT_BIT      = 0;

    // ****************************************************************
    // bus access phases
    // ****************************************************************
    typedef enum logic [1:0] {
        ISEL_IDLE   = 2'b00,
        ISEL_SETUP  = 2'b01,
        ISEL_ACCESS = 2'b10
    } isel_phase_type;
endpackage

/* rtl/isel_enable_reg.sv */
`timescale 1ns/1ps
// one source enable register and the line it gates
module isel_enable_reg #(
    parameter int           WIDTH     = 32,
    parameter logic [31:0]  RESET_VAL = isel_pkg::EN_RESET,
    parameter logic [31:0]  MASK      = isel_pkg::SRC_MASK
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [WIDTH-1:0] pend,
    output logic      [WIDTH-1:0] en_reg,
    output logic      [WIDTH-1:0] flags_reg,
    output logic                  irq_reg
);
    // the masks and reset value are one word wide, so only 32 fits
    if (WIDTH != 32) begin : g_bad_width
        $error("isel_enable_reg serves 32 bits only");
    end

    // reserved bits are never stored, so they always read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            en_reg <= RESET_VAL;                     // see RULE_01
        end else if (wr_en) begin
            en_reg <= wr_data & MASK;                // see RULE_03
        end
    end

    // flags show pending sources in the enable layout
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_reg <= isel_pkg::FLAG_RESET;
        end else begin
            flags_reg <= pend & MASK;                // see RULE_11
        end
    end

    // registered line so the host sees a glitch-free level
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(pend & en_reg & MASK);      // see RULE_12
        end
    end
endmodule

/* rtl/isel_apb_decode.sv */
`timescale 1ns/1ps
// apb address decode; zero wait states
module isel_apb_decode (
    input  wire logic [15:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    output logic             wr_line0,
    output logic             wr_line1,
    output logic [2:0]       rd_sel,
    output logic             unmapped
);
    logic acc;

    // writes act only in the access phase
    always_comb begin
        acc      = psel && penable;
        wr_line0 = acc && pwrite && (paddr == isel_pkg::LINE0_EN_OFFSET);
        wr_line1 = acc && pwrite && (paddr == isel_pkg::LINE1_EN_OFFSET);
        unmapped = 1'b0;
        case (paddr)
            isel_pkg::LINE0_EN_OFFSET:   rd_sel = 3'd1;
            isel_pkg::LINE1_EN_OFFSET:   rd_sel = 3'd2;
            isel_pkg::LINE0_FLAG_OFFSET: begin
                rd_sel   = 3'd3;
                unmapped = pwrite;          // flags are read only
            end
            isel_pkg::LINE1_FLAG_OFFSET: begin
                rd_sel   = 3'd4;
                unmapped = pwrite;
            end
            default: begin
                rd_sel   = 3'd0;
                unmapped = 1'b1;
            end
        endcase
    end
endmodule

/* rtl/isel_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01 - two 32-bit enable registers at consecutive words, reset 0x00002000
// RULE_02 - bit 13 gates boot done, enabled on both lines after reset
// RULE_03 - bit 31 break attempt, bit 29 outlier; one enables, zero disables
// RULE_04 - bits 27..23 fifo underflow, overflow, threshold, empty, full
// RULE_05 - bit 17 sequencer timeout error, bit 16 timeout done, reset off
// RULE_06 - bit 15 end of sequence enable, reset zero
// RULE_07 - bits 12..9 custom events three down to zero, reset zero
// RULE_08 - bits 8..4 variance, mean, adc delta, max, min fail
// RULE_09 - bits 3..0 temperature, filter ready, dft, adc result
// RULE_10 - first register steers line zero, second steers line one
// RULE_11 - each line has a read-only flag register in enable layout
// RULE_12 - line asserts when any pending source is enabled for it
// RULE_13 - software writes zero to reserved bits, ignores their value
module isel_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] src_pending,
    output logic             irq_line_zero,
    output logic             irq_line_one
);
    // ****************************************************************
    // decode
    // ****************************************************************
    logic        wr_line0;
    logic        wr_line1;
    logic [2:0]  rd_sel;
    logic        unmapped;
    logic [31:0] line0_source_enable;
    logic [31:0] line1_source_enable;
    logic [31:0] line0_flags;
    logic [31:0] line1_flags;

    isel_apb_decode u_dec (
        .paddr    (paddr),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .wr_line0 (wr_line0),
        .wr_line1 (wr_line1),
        .rd_sel   (rd_sel),
        .unmapped (unmapped)
    );

    // ****************************************************************
    // one enable register per line
    // ****************************************************************
    // see RULE_10: line zero register feeds irq_line_zero only
    isel_enable_reg u_line0 (
        .clk       (clk),
        .rst       (rst),
        .wr_en     (wr_line0),
        .wr_data   (pwdata),
        .pend      (src_pending),
        .en_reg    (line0_source_enable),
        .flags_reg (line0_flags),
        .irq_reg   (irq_line_zero)
    );

    isel_enable_reg u_line1 (
        .clk       (clk),
        .rst       (rst),
        .wr_en     (wr_line1),
        .wr_data   (pwdata),
        .pend      (src_pending),
        .en_reg    (line1_source_enable),
        .flags_reg (line1_flags),
        .irq_reg   (irq_line_one)
    );

    // ****************************************************************
    // apb answer
    // ****************************************************************
    // zero wait states keep the master simple
    assign pready  = 1'b1;
    assign pslverr = psel && penable && unmapped;

    // read data registered? no: combinational mux of register outputs
    always_comb begin
        case (rd_sel)
            3'd1:    prdata = line0_source_enable;      // see RULE_13
            3'd2:    prdata = line1_source_enable;
            3'd3:    prdata = line0_flags;              // see RULE_11
            3'd4:    prdata = line1_flags;
            default: prdata = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // field views of line zero
    // ****************************************************************
    // named views let each source be checked against its own rule
    logic [31:0] en0;
    logic        break_attempt_en;
    logic        outlier_en;
    logic        fifo_underflow_en;
    logic        fifo_overflow_en;
    logic        fifo_threshold_en;
    logic        fifo_empty_en;
    logic        fifo_full_en;
    logic        seq_timeout_error_en;
    logic        seq_timeout_done_en;
    logic        seq_end_en;
    logic        boot_done_en;
    logic        custom3_en;
    logic        custom2_en;
    logic        custom1_en;
    logic        custom0_en;
    logic        variance_en;
    logic        mean_en;
    logic        adc_delta_fail_en;
    logic        adc_max_fail_en;
    logic        adc_min_fail_en;
    logic        temp_result_en;
    logic        filter_ready_en;
    logic        dft_result_en;
    logic        adc_result_en;

    // short alias keeps the view lines readable
    assign en0                  = line0_source_enable;
    // break and outlier
    assign break_attempt_en     = en0[isel_pkg::BREAK_ATTEMPT_BIT];
    assign outlier_en           = en0[isel_pkg::OUTLIER_BIT];
    // data fifo group
    assign fifo_underflow_en    = en0[isel_pkg::FIFO_UNDERFLOW_BIT];
    assign fifo_overflow_en     = en0[isel_pkg::FIFO_OVERFLOW_BIT];
    assign fifo_threshold_en    = en0[isel_pkg::FIFO_THRESHOLD_BIT];
    assign fifo_empty_en        = en0[isel_pkg::FIFO_EMPTY_BIT];
    assign fifo_full_en         = en0[isel_pkg::FIFO_FULL_BIT];
    // sequencer group and boot done
    assign seq_timeout_error_en = en0[isel_pkg::SEQ_TMO_ERROR_BIT];
    assign seq_timeout_done_en  = en0[isel_pkg::SEQ_TMO_DONE_BIT];
    assign seq_end_en           = en0[isel_pkg::SEQ_END_BIT];
    assign boot_done_en         = en0[isel_pkg::BOOT_DONE_BIT];
    // custom events
    assign custom3_en           = en0[isel_pkg::CUSTOM3_BIT];
    assign custom2_en           = en0[isel_pkg::CUSTOM2_BIT];
    assign custom1_en           = en0[isel_pkg::CUSTOM1_BIT];
    assign custom0_en           = en0[isel_pkg::CUSTOM0_BIT];
    // statistics and adc limit checks
    assign variance_en          = en0[isel_pkg::VARIANCE_BIT];
    assign mean_en              = en0[isel_pkg::MEAN_BIT];
    assign adc_delta_fail_en    = en0[isel_pkg::ADC_DELTA_BIT];
    assign adc_max_fail_en      = en0[isel_pkg::ADC_MAX_BIT];
    assign adc_min_fail_en      = en0[isel_pkg::ADC_MIN_BIT];
    // result events
    assign temp_result_en       = en0[isel_pkg::TEMP_RESULT_BIT];
    assign filter_ready_en      = en0[isel_pkg::FILTER_READY_BIT];
    assign dft_result_en        = en0[isel_pkg::DFT_RESULT_BIT];
    assign adc_result_en        = en0[isel_pkg::ADC_RESULT_BIT];

    // ****************************************************************
    // checks
    // ****************************************************************
    // all checks run on the one clock and sleep through reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_reset_value: assert property ( // see RULE_01
        $past(rst) |-> line0_source_enable == isel_pkg::EN_RESET
                    && line1_source_enable == isel_pkg::EN_RESET)
        else $error("enable reset value wrong");
    a_boot_default: assert property ( // see RULE_02
        $past(rst) |-> boot_done_en
                    && line1_source_enable[isel_pkg::BOOT_DONE_BIT])
        else $error("boot done not enabled after reset");
    a_boot_gate: assert property ( // see RULE_02
        src_pending[isel_pkg::BOOT_DONE_BIT] && boot_done_en
        |=> irq_line_zero)
        else $error("boot done does not reach line zero");
    a_write_takes: assert property ( // see RULE_03
        wr_line0 |=> line0_source_enable
                     == ($past(pwdata) & isel_pkg::SRC_MASK))
        else $error("line zero enable write lost");
    a_write_one: assert property ( // see RULE_10
        wr_line1 |=> line1_source_enable
                     == ($past(pwdata) & isel_pkg::SRC_MASK))
        else $error("line one enable write lost");
    a_break_gate: assert property ( // see RULE_03
        (src_pending[isel_pkg::BREAK_ATTEMPT_BIT] && break_attempt_en)
        || (src_pending[isel_pkg::OUTLIER_BIT] && outlier_en)
        |=> irq_line_zero)
        else $error("break or outlier does not reach line zero");
    a_fifo_reset: assert property ( // see RULE_04
        $past(rst) |-> !(fifo_underflow_en || fifo_overflow_en
                    || fifo_threshold_en || fifo_empty_en || fifo_full_en))
        else $error("fifo enables not clear after reset");
    a_fifo_gate: assert property ( // see RULE_04
        |(src_pending[isel_pkg::FIFO_UNDERFLOW_BIT:isel_pkg::FIFO_FULL_BIT]
          & {fifo_underflow_en, fifo_overflow_en, fifo_threshold_en,
             fifo_empty_en, fifo_full_en})
        |=> irq_line_zero)
        else $error("fifo event does not reach line zero");
    a_seq_reset: assert property ( // see RULE_05
        $past(rst) |-> !(seq_timeout_error_en || seq_timeout_done_en))
        else $error("sequencer timeout enables not clear after reset");
    a_seq_gate: assert property ( // see RULE_05
        (src_pending[isel_pkg::SEQ_TMO_ERROR_BIT] && seq_timeout_error_en)
        || (src_pending[isel_pkg::SEQ_TMO_DONE_BIT] && seq_timeout_done_en)
        |=> irq_line_zero)
        else $error("sequencer timeout does not reach line zero");
    a_end_gate: assert property ( // see RULE_06
        src_pending[isel_pkg::SEQ_END_BIT] && seq_end_en
        |=> irq_line_zero)
        else $error("end of sequence does not reach line zero");
    a_end_reset: assert property ( // see RULE_06
        $past(rst) |-> !seq_end_en)
        else $error("end of sequence enable not clear after reset");
    a_custom_gate: assert property ( // see RULE_07
        |(src_pending[isel_pkg::CUSTOM3_BIT:isel_pkg::CUSTOM0_BIT]
          & {custom3_en, custom2_en, custom1_en, custom0_en})
        |=> irq_line_zero)
        else $error("custom event does not reach line zero");
    a_custom_reset: assert property ( // see RULE_07
        $past(rst) |-> !(custom3_en || custom2_en || custom1_en || custom0_en))
        else $error("custom enables not clear after reset");
    a_stats_gate: assert property ( // see RULE_08
        |(src_pending[isel_pkg::VARIANCE_BIT:isel_pkg::ADC_MIN_BIT]
          & {variance_en, mean_en, adc_delta_fail_en, adc_max_fail_en,
             adc_min_fail_en})
        |=> irq_line_zero)
        else $error("statistics event does not reach line zero");
    a_result_gate: assert property ( // see RULE_09
        |(src_pending[isel_pkg::TEMP_RESULT_BIT:isel_pkg::ADC_RESULT_BIT]
          & {temp_result_en, filter_ready_en, dft_result_en, adc_result_en})
        |=> irq_line_zero)
        else $error("result event does not reach line zero");
    a_reserved_zero: assert property ( // see RULE_13
        (line0_source_enable & ~isel_pkg::SRC_MASK) == 32'h0000_0000)
        else $error("reserved bit stored");
    a_line_one_hold: assert property ( // see RULE_10
        !wr_line1 |=> $stable(line1_source_enable))
        else $error("line one enable changed without write");
    a_line_zero_hold: assert property ( // see RULE_10
        !wr_line0 |=> $stable(line0_source_enable))
        else $error("line zero enable changed without write");
    a_irq_zero: assert property ( // see RULE_12
        1 |=> irq_line_zero
              == |($past(src_pending) & $past(line0_source_enable)))
        else $error("line zero level wrong");
    a_irq_one: assert property ( // see RULE_12
        1 |=> irq_line_one
              == |($past(src_pending) & $past(line1_source_enable)))
        else $error("line one level wrong");
    a_flag_view: assert property ( // see RULE_11
        1 |=> line1_flags == ($past(src_pending) & isel_pkg::SRC_MASK))
        else $error("line one flag register mismatch");
    a_flag_zero: assert property ( // see RULE_11
        1 |=> line0_flags == ($past(src_pending) & isel_pkg::SRC_MASK))
        else $error("line zero flag register mismatch");

    // every source bit gates line one alike; reserved bits never store
    for (genvar b = 0; b < 32; b++) begin : g_bit
        if (isel_pkg::SRC_MASK[b]) begin : g_src
            a_bit_gate: assert property ( // see RULE_12
                src_pending[b] && line1_source_enable[b] |=> irq_line_one)
                else $error("enabled source missing on line one");
        end else begin : g_rsv
            a_bit_reserved: assert property ( // see RULE_13
                !line0_source_enable[b] && !line1_source_enable[b])
                else $error("reserved enable bit stored");
        end
    end

    // main scenarios: both writes, line zero raised, line one alone, a refused access
    c_write0: cover property (wr_line0);
    c_write1: cover property (wr_line1);
    c_irq0:   cover property (irq_line_zero);
    c_irq1:   cover property (irq_line_one && !irq_line_zero);
    c_err:    cover property (pslverr);
endmodule

/* sim/isel_host_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// host side: samples both interrupt lines on its own clock edge
// ****************************************************************
module isel_host_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       irq_line_zero,
    input  wire logic       irq_line_one,
    output logic      [1:0] irq_seen
);
    // registered view only: a host never acts on a half-settled level
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_seen <= 2'b00;
        end else begin
            irq_seen <= {irq_line_one, irq_line_zero};
        end
    end
endmodule

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
    // ****************************************************************
    // stimulus, hookup and bookkeeping
    // ****************************************************************
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000, src_pending = 32'h0000_0000;
    logic [31:0] prdata, rd, en0, en1, p, lfsr = 32'h0000_bf6a;
    logic        pready, pslverr, irq_line_zero, irq_line_one, err;
    logic [1:0]  irq_seen;
    int          err_count = 0, num_checks = 0, cyc = 0;
    localparam logic [31:0] MSK = isel_pkg::SRC_MASK;
    always #2.5 clk = ~clk;
    isel_top isel_top_i (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_pending(src_pending), .irq_line_zero(irq_line_zero),
        .irq_line_one(irq_line_one));
    isel_host_model isel_host_model_i (.clk(clk), .rst(rst),
        .irq_line_zero(irq_line_zero), .irq_line_one(irq_line_one),
        .irq_seen(irq_seen));
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            report_and_stop();
        end
    end
    function logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function logic [31:0] exp_irq(input logic [31:0] e0, e1, pd);
        return {30'h0, |(e1 & pd & MSK), |(e0 & pd & MSK)};
    endfunction
    task check(input logic [31:0] got, exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task report_and_stop();
        if (err_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // apb cycle: setup, then access held until pready is seen high
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // irq is registered, the host adds one more stage
    task drive_check(input logic [31:0] pd);
        src_pending <= pd;
        repeat (3) @(posedge clk);
        check({30'h0, irq_line_one, irq_line_zero}, exp_irq(en0, en1, pd),
              "irq lines");
        check({30'h0, irq_seen}, exp_irq(en0, en1, pd),
              "host view");
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        en0 = isel_pkg::EN_RESET;
        en1 = isel_pkg::EN_RESET;
        apb(0, isel_pkg::LINE0_EN_OFFSET, 0);
        check(rd, en0, "line0 reset");
        check({31'h0, err}, 0, "mapped read error");
        check({31'h0, pready}, 1, "ready level");
        apb(0, isel_pkg::LINE1_EN_OFFSET, 0);
        check(rd, en1, "line1 reset");
        drive_check(32'h0000_2000);
        apb(0, isel_pkg::LINE0_FLAG_OFFSET, 0);
        check(rd, 32'h0000_2000, "flag0");
        // one source at a time: line0 alone, then everything else on line1
        for (int b = 0; b < 32; b++) begin
            en0 = (32'h1 << b) & MSK;
            en1 = en0 ^ MSK; // reserved stays zero
            apb(1, isel_pkg::LINE0_EN_OFFSET, en0);
            apb(1, isel_pkg::LINE1_EN_OFFSET, en1);
            apb(0, isel_pkg::LINE0_EN_OFFSET, 0);
            check(rd, en0, "walk rb");
            drive_check(32'h1 << b);
        end
        for (int i = 0; i < 24; i++) begin
            lfsr = lfsr_next(lfsr);
            en0 = lfsr & MSK;
            lfsr = lfsr_next(lfsr);
            en1 = lfsr & MSK;
            lfsr = lfsr_next(lfsr);
            p = (i < 4) ? 32'h0000_0000 : lfsr & lfsr_next(lfsr);
            apb(1, isel_pkg::LINE0_EN_OFFSET, en0);
            apb(1, isel_pkg::LINE1_EN_OFFSET, en1);
            drive_check(p);
            apb(0, isel_pkg::LINE1_FLAG_OFFSET, 0);
            check(rd, p & MSK, "flag1");
            apb(0, isel_pkg::LINE1_EN_OFFSET, 0);
            check(rd, en1, "line1 rb");
        end
        apb(1, isel_pkg::LINE0_FLAG_OFFSET, 32'hffff_ffff);
        check({31'h0, err}, 1, "flag write");
        apb(0, 16'h3018, 0);
        check({31'h0, err}, 1, "unmapped");
        apb(0, isel_pkg::LINE0_FLAG_OFFSET, 0);
        check(rd, p & MSK, "flag0 kept");
        rst <= 1;
        @(posedge clk);
        rst <= 0;
        apb(0, isel_pkg::LINE1_EN_OFFSET, 0);
        check(rd, isel_pkg::EN_RESET, "second reset");
        report_and_stop();
    end
endmodule
